// ===== pbr_core.sv
/*
  Buffered compare-value and load-control logic of one PWM submodule.
  Software writes shadow registers; a load moves them to the active set.
  The active set feeds the counter and waveform logic, which live outside.
  Assumes reload and init events come from the counter logic outside.
  Assumes one bus clock for everything and a synchronous, active-high reset.
  Assumes a master that holds each request until waitrequest is seen low.
*/
`timescale 1ns/100ps

module pbr_core (
  // Clock and reset.
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  // Avalon-MM slave.
  input  wire logic [7:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // Events from the counter logic.
  input  wire logic                  reload_opportunity,
  input  wire logic                  init_signal,
  // Active set and events towards the counter and output logic.
  output pbr_pkg::pbr_set_t          active_set,
  output logic                       load_event,
  output logic                       counter_restart,
  output logic                       force_out_event,
  output logic                       shadow_load_ok
);
  import pbr_pkg::*;

  // Register map, byte offsets on the bus:
  //   0x00 load control: bit 0 sets load-ok, bit 1 clears it, bit 2 forces an override.
  //   0x04 setup: prescale in 2:0 (buffered), immediate load in bit 4 and
  //        override source in 10:8, where zero selects the local software source.
  //   0x08 counter start value, shadow copy, in 15:0.
  //   0x0C status: bit 0 is load-ok, bit 1 is the load event of the last cycle.
  //   0x10 to 0x24 shadow thresholds, one word for each index.
  //   0x30 to 0x44 active thresholds, read only.
  //   0x48 active start value and 0x4C active prescale, both read only.
  // Unmapped offsets read as zero and ignore writes.

  // Register state.
  pbr_set_t    shadow_q;
  pbr_set_t    active_q;
  logic        shadow_load_ok_q;
  logic        imm_q;
  logic [2:0]  fsel_q;
  logic        sw_force_q;
  logic        load_q;
  logic        restart_q;
  logic        ack_q;
  logic [31:0] rdata_q;

  // Bus handshake and write decode.
  logic        req;
  logic        wr_go;
  logic        rd_go;

  // Load control.
  logic        blocked;
  logic        do_load;
  logic        shadow_load_ok_set;
  logic        shadow_load_ok_clr;
  logic        sw_force;

  // Threshold window decode.
  logic [7:0]  rel;
  logic [2:0]  vidx;
  logic        in_val;
  logic        in_act;

  // Read path.
  logic [31:0] rd_d;

  // One wait cycle per access keeps read data registered; the answer comes
  // on the second edge of the request.
  // A write commits on the first edge, while waitrequest is still high; this
  // is safe because the master holds the request, and ack_q keeps a held
  // request from committing twice. The trade-off is one idle cycle per
  // access against a read path with no combinational output.
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_go           = avs_write & ~ack_q;
  assign rd_go           = avs_read & ~ack_q;
  assign avs_readdata    = rdata_q;

  // Threshold window decode, one word per index.
  // Address bits 1:0 are ignored, so a byte address inside a word selects it.
  // Indices six and seven cannot occur inside either window.
  // Each window is six words long; the two slots after the shadow window read as zero.
  assign in_val = (avs_address >= PBR_OFS_VAL_BASE) &&
                  (avs_address < PBR_OFS_VAL_BASE + 8'(4 * PBR_NUM_VAL));
  assign in_act = (avs_address >= PBR_OFS_ACT_BASE) &&
                  (avs_address < PBR_OFS_ACT_BASE + 8'(4 * PBR_NUM_VAL));
  assign rel    = in_act ? (avs_address - PBR_OFS_ACT_BASE)
                         : (avs_address - PBR_OFS_VAL_BASE);
  assign vidx   = rel[4:2];

  // Load-ok mask bits in the load-control register.
  // One submodule lives here, so each mask is a single bit; set and clear in
  // one write leave the flag clear.
  // A force with another source selected is dropped, not held for later.
  assign shadow_load_ok_set = wr_go && (avs_address == PBR_OFS_LOAD_CTRL) &&
                    avs_writedata[PBR_LC_SET_BIT] && avs_byteenable[0];
  assign shadow_load_ok_clr = wr_go && (avs_address == PBR_OFS_LOAD_CTRL) &&
                    avs_writedata[PBR_LC_CLR_BIT] && avs_byteenable[0];
  assign sw_force = wr_go && (avs_address == PBR_OFS_LOAD_CTRL) &&
                    avs_writedata[PBR_LC_FORCE_BIT] && avs_byteenable[0] &&
                    (fsel_q == PBR_FSEL_LOCAL_SW);

  // Buffered values are locked while the load is armed.
  // Software is expected to wait for the flag to drop; a blocked write is
  // dropped without any error response, so a careless driver loses data.
  assign blocked = shadow_load_ok_q;

  // Load fires at the reload opportunity or at once, as configured.
  // Load timing, counted in edges from the flag write:
  //   edge 1 sets the flag; in immediate mode the load is decided next cycle,
  //   edge 2 copies shadow to active and clears the flag,
  //   edge 3 drops the load event pulse that edge 2 raised.
  // In reload mode edge 2 waits for a cycle with the reload opportunity high.
  assign do_load = shadow_load_ok_q && (imm_q || reload_opportunity);

  // Bus handshake flag.
  // It is high in the second cycle of a request and low between requests.
  // Reads and writes share the same single wait cycle.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Load-ok flag; the hardware clear on load wins over a same-cycle set,
  // since the set would otherwise re-arm a load of values already moved.
  // A clear written by software in the load cycle changes nothing, since the
  // load clears the flag as well.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shadow_load_ok_q <= 1'b0;
    end else if (do_load) begin
      shadow_load_ok_q <= 1'b0;
    end else if (shadow_load_ok_clr) begin
      shadow_load_ok_q <= 1'b0;
    end else if (shadow_load_ok_set) begin
      shadow_load_ok_q <= 1'b1;
    end
  end

  // Override source; not buffered, so it may change while a load is armed.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fsel_q <= PBR_RST_FSEL;
    end else if (wr_go && (avs_address == PBR_OFS_SETUP) && avs_byteenable[1]) begin
      fsel_q <= avs_writedata[PBR_SU_FSEL_MSB:PBR_SU_FSEL_LSB];
    end
  end

  // Load timing select; also unbuffered, so it applies to the armed load.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      imm_q <= 1'b0;
    end else if (wr_go && (avs_address == PBR_OFS_SETUP) && avs_byteenable[0]) begin
      imm_q <= avs_writedata[PBR_SU_IMM_BIT];
    end
  end

  // Shadow set; writes are dropped while the load is armed.
  // Byte lanes are honoured, so a 16-bit write can update half a word.
  // Index zero keeps no fraction; its lane-1 bits are dropped.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shadow_q.prescale <= PBR_RST_CLOCK_PRESCALE_FIELD;
      shadow_q.start    <= PBR_RST_START;
      for (int i = 0; i < PBR_NUM_VAL; i++) begin
        shadow_q.thr[i].whole <= PBR_RST_VAL;
        shadow_q.thr[i].frac  <= PBR_RST_FRAC;
      end
    end else if (wr_go && !blocked) begin
      if (avs_address == PBR_OFS_SETUP && avs_byteenable[0]) begin
        shadow_q.prescale <= avs_writedata[PBR_SU_CLOCK_PRESCALE_FIELD_MSB:PBR_SU_CLOCK_PRESCALE_FIELD_LSB];
      end
      if (avs_address == PBR_OFS_START) begin
        if (avs_byteenable[0]) shadow_q.start[7:0]  <= avs_writedata[7:0];
        if (avs_byteenable[1]) shadow_q.start[15:8] <= avs_writedata[15:8];
      end
      if (in_val) begin
        if (avs_byteenable[2]) shadow_q.thr[vidx].whole[7:0]  <= avs_writedata[23:16];
        if (avs_byteenable[3]) shadow_q.thr[vidx].whole[15:8] <= avs_writedata[31:24];
        if (avs_byteenable[1] && vidx != 3'h0) begin
          shadow_q.thr[vidx].frac <= avs_writedata[PBR_W_FRAC_MSB:PBR_W_FRAC_LSB];
        end
      end
    end
  end

  // Active set takes the whole shadow at the load.
  // The whole set moves in one edge, so the counter never sees a mix of old
  // and new thresholds at once, nor within one period in reload mode.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      active_q.prescale <= PBR_RST_CLOCK_PRESCALE_FIELD;
      active_q.start    <= PBR_RST_START;
      for (int i = 0; i < PBR_NUM_VAL; i++) begin
        active_q.thr[i].whole <= PBR_RST_VAL;
        active_q.thr[i].frac  <= PBR_RST_FRAC;
      end
    end else if (do_load) begin
      active_q <= shadow_q;
    end
  end

  // Load event, raised by the load edge for one cycle; status bit 1 shows it as well.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      load_q <= 1'b0;
    end else begin
      load_q <= do_load;
    end
  end

  // Override event, raised only for an accepted software force.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sw_force_q <= 1'b0;
    end else begin
      sw_force_q <= sw_force;
    end
  end

  // Counter restart; the counter outside reloads the active start value on it.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= init_signal | sw_force;
    end
  end

  // Read mux; fraction of index zero and reserved bits read as zero.
  // The threshold offsets show the shadow copy, so software can read back
  // what it wrote before a load moves it.
  // Unmapped offsets fall through every branch and read as zero.
  always_comb begin
    rd_d = 32'h0000_0000;
    if (avs_address == PBR_OFS_LOAD_CTRL) begin
      rd_d[PBR_LC_SET_BIT] = shadow_load_ok_q;
    end else if (avs_address == PBR_OFS_SETUP) begin
      rd_d[PBR_SU_CLOCK_PRESCALE_FIELD_MSB:PBR_SU_CLOCK_PRESCALE_FIELD_LSB] = shadow_q.prescale;
      rd_d[PBR_SU_IMM_BIT]                  = imm_q;
      rd_d[PBR_SU_FSEL_MSB:PBR_SU_FSEL_LSB] = fsel_q;
    end else if (avs_address == PBR_OFS_START) begin
      rd_d[15:0] = shadow_q.start;
    end else if (avs_address == PBR_OFS_STATUS) begin
      rd_d[0] = shadow_load_ok_q;
      rd_d[1] = load_q;
    end else if (in_val) begin
      rd_d[31:PBR_W_INT_LSB]              = shadow_q.thr[vidx].whole;
      rd_d[PBR_W_FRAC_MSB:PBR_W_FRAC_LSB] = shadow_q.thr[vidx].frac;
    end else if (in_act) begin
      rd_d[31:PBR_W_INT_LSB]              = active_q.thr[vidx].whole;
      rd_d[PBR_W_FRAC_MSB:PBR_W_FRAC_LSB] = active_q.thr[vidx].frac;
    end else if (avs_address == PBR_OFS_ACT_START) begin
      rd_d[15:0] = active_q.start;
    end else if (avs_address == PBR_OFS_ACT_SETUP) begin
      rd_d[PBR_SU_CLOCK_PRESCALE_FIELD_MSB:PBR_SU_CLOCK_PRESCALE_FIELD_LSB] = active_q.prescale;
    end
  end

  // Registered read data, captured when the read is taken.
  // Capturing only in the first cycle keeps the data steady while waitrequest is low.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_go) begin
      rdata_q <= rd_d;
    end
  end

  // Outputs come straight from flip-flops, so the counter logic sees no decode glitch.
  assign active_set      = active_q;
  assign load_event      = load_q;
  assign force_out_event = sw_force_q;
  assign counter_restart = restart_q;
  assign shadow_load_ok  = shadow_load_ok_q;

endmodule : pbr_core

// ===== pbr_core_asserts.sv
/* Port checker for the buffered compare and reload block.
   Assumes one sys_clk domain and the synchronous sys_rst of that domain. */
`timescale 1ns/100ps
module pbr_asserts (
  // Clock and reset.
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  // Bus handshake.
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic              avs_waitrequest,
  // Events and active set.
  input wire logic              reload_opportunity,
  input wire logic              init_signal,
  input wire pbr_pkg::pbr_set_t active_set,
  input wire logic              load_event,
  input wire logic              counter_restart,
  input wire logic              force_out_event,
  input wire logic              shadow_load_ok
);
  import pbr_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // A load drops the flag at once and reports within one more cycle.
  sequence s_load_done;
    !shadow_load_ok ##[0:1] load_event;
  endsequence

  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request waited more than one cycle");
  a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high without a request");
  a_load_clear: assert property (shadow_load_ok && reload_opportunity |=> s_load_done)
    else $error("load did not clear the flag or report");
  a_active_hold: assert property (!shadow_load_ok |=> $stable(active_set))
    else $error("active set moved without the flag");
  a_event_one: assert property (load_event |=> !load_event)
    else $error("load event longer than one cycle");
  a_init_restart: assert property (init_signal |=> counter_restart)
    else $error("init did not restart the counter");
  a_force_restart: assert property (force_out_event |-> counter_restart)
    else $error("force without counter restart");
  a_restart_cause: assert property (
    counter_restart |-> $past(init_signal) || force_out_event)
    else $error("counter restart without a cause");
endmodule : pbr_asserts

bind pbr_core pbr_asserts u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .reload_opportunity(reload_opportunity), .init_signal(init_signal),
  .active_set(active_set), .load_event(load_event), .counter_restart(counter_restart),
  .force_out_event(force_out_event), .shadow_load_ok(shadow_load_ok));

// ===== pbr_pkg.sv
/*
  Package for the buffered compare and reload block of one PWM submodule.
  Holds register offsets, field positions, reset values and the shared structs.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package pbr_pkg;

  // Register byte offsets.
  localparam logic [7:0] PBR_OFS_LOAD_CTRL  = 8'h00;
  localparam logic [7:0] PBR_OFS_SETUP      = 8'h04;
  localparam logic [7:0] PBR_OFS_START      = 8'h08;
  localparam logic [7:0] PBR_OFS_STATUS     = 8'h0C;
  localparam logic [7:0] PBR_OFS_VAL_BASE   = 8'h10;
  localparam logic [7:0] PBR_OFS_ACT_BASE   = 8'h30;
  localparam logic [7:0] PBR_OFS_ACT_START  = 8'h48;
  localparam logic [7:0] PBR_OFS_ACT_SETUP  = 8'h4C;

  // Number of compare thresholds; index zero has no fraction.
  localparam int         PBR_NUM_VAL        = 6;

  // Load-control register fields.
  localparam int         PBR_LC_SET_BIT     = 0;
  localparam int         PBR_LC_CLR_BIT     = 1;
  localparam int         PBR_LC_FORCE_BIT   = 2;

  // Setup register fields.
  localparam int         PBR_SU_CLOCK_PRESCALE_FIELD_LSB    = 0;
  localparam int         PBR_SU_CLOCK_PRESCALE_FIELD_MSB    = 2;
  localparam int         PBR_SU_IMM_BIT     = 4;
  localparam int         PBR_SU_FSEL_LSB    = 8;
  localparam int         PBR_SU_FSEL_MSB    = 10;
  localparam logic [2:0] PBR_FSEL_LOCAL_SW  = 3'h0;

  // Combined threshold word layout.
  localparam int         PBR_W_INT_LSB      = 16;
  localparam int         PBR_W_FRAC_LSB     = 11;
  localparam int         PBR_W_FRAC_MSB     = 15;

  // Reset values.
  localparam logic [15:0] PBR_RST_START     = 16'h0000;
  localparam logic [15:0] PBR_RST_VAL       = 16'h0000;
  localparam logic [4:0]  PBR_RST_FRAC      = 5'h00;
  localparam logic [2:0]  PBR_RST_CLOCK_PRESCALE_FIELD      = 3'h0;
  localparam logic [2:0]  PBR_RST_FSEL      = 3'h0;

  // One threshold: integer and fractional part.
  typedef struct packed {
    logic [15:0] whole;
    logic [4:0]  frac;
  } pbr_thr_t;

  // The full buffered set that moves on a load.
  typedef struct packed {
    logic [2:0]  prescale;
    logic [15:0] start;
    pbr_thr_t [PBR_NUM_VAL-1:0] thr;
  } pbr_set_t;

endpackage : pbr_pkg

// ===== tb_top.sv
/* Self-checking bench for the buffered compare and reload block.
   Drives bus and counter events directly; the checker is bound in. */
`timescale 1ns/100ps
module tb_top;
  import pbr_pkg::*;
  logic        sys_clk, sys_rst, avs_read, avs_write, reload_opportunity, init_signal;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_q;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest, load_event, counter_restart, force_out_event, shadow_load_ok;
  pbr_set_t    active_set;
  int          err_total, n_checks, n_frc, n_rst, n_ld;

  pbr_core dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .reload_opportunity(reload_opportunity),
    .init_signal(init_signal), .active_set(active_set), .load_event(load_event),
    .counter_restart(counter_restart), .force_out_event(force_out_event),
    .shadow_load_ok(shadow_load_ok));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Pulses are counted mid-cycle, where they are settled, to avoid edge races.
  always @(negedge sys_clk) begin
    n_frc += int'(force_out_event === 1'b1);
    n_rst += int'(counter_restart === 1'b1);
    n_ld  += int'(load_event === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bus cycle: hold the request until waitrequest is seen low at an edge.
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic wr_en);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr_en;
    avs_read      <= ~wr_en;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 32'h0, 1'b0);
    chk(rd_q, e);
  endtask : rchk

  task automatic pulse_reload;
    reload_opportunity <= 1'b1;
    @(posedge sys_clk);
    reload_opportunity <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : pulse_reload

  task report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Watchdog sized well above the roughly 150 cycles the tests need.
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  initial begin
    {sys_rst, avs_read, avs_write, reload_opportunity, init_signal} = 5'h10;
    {avs_address, avs_writedata, avs_byteenable} = {8'h00, 32'h0, 4'hF};
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rchk(PBR_OFS_ACT_START, 32'h0);
    // Reserved bits are written as ones; they must read back as zero.
    for (int i = 0; i < PBR_NUM_VAL; i++)
      bus(PBR_OFS_VAL_BASE + 8'(4*i), {16'h1000 + 16'(i), 5'h15, 11'h7FF}, 1'b1);
    bus(PBR_OFS_START, 32'h0000ABCD, 1'b1);
    bus(PBR_OFS_SETUP, 32'h00000005, 1'b1);
    for (int i = 0; i < PBR_NUM_VAL; i++) begin
      rchk(PBR_OFS_VAL_BASE + 8'(4*i), {16'h1000 + 16'(i), (i == 0) ? 5'h00 : 5'h15, 11'h0});
      rchk(PBR_OFS_ACT_BASE + 8'(4*i), 32'h0);
    end
    pulse_reload();
    chk(32'(active_set.start), 32'h0);
    bus(PBR_OFS_LOAD_CTRL, 32'h1, 1'b1);
    rchk(PBR_OFS_LOAD_CTRL, 32'h1);
    rchk(PBR_OFS_STATUS, 32'h1);
    chk(32'(shadow_load_ok), 32'h1);
    bus(PBR_OFS_VAL_BASE, 32'hDEAD0000, 1'b1);
    bus(PBR_OFS_START, 32'h00000001, 1'b1);
    rchk(PBR_OFS_VAL_BASE, 32'h10000000);
    pulse_reload();
    chk(32'(active_set.start), 32'h0000ABCD);
    chk(32'(active_set.prescale), 32'h5);
    for (int i = 1; i < PBR_NUM_VAL; i++)
      chk(32'(active_set.thr[i]), 32'({16'h1000 + 16'(i), 5'h15}));
    chk(32'(n_ld), 32'h1);
    rchk(PBR_OFS_LOAD_CTRL, 32'h0);
    // Immediate mode loads without any reload opportunity.
    bus(PBR_OFS_SETUP, 32'h00000012, 1'b1);
    bus(PBR_OFS_START, 32'h00000077, 1'b1);
    bus(PBR_OFS_LOAD_CTRL, 32'h1, 1'b1);
    @(posedge sys_clk);
    chk(32'(active_set.start), 32'h77);
    chk(32'(active_set.prescale), 32'h2);
    rchk(PBR_OFS_ACT_SETUP, 32'h2);
    rchk(PBR_OFS_LOAD_CTRL, 32'h0);
    // Clear by mask, and clear winning over set in one write, so no load follows.
    bus(PBR_OFS_SETUP, 32'h0, 1'b1);
    bus(PBR_OFS_LOAD_CTRL, 32'h1, 1'b1);
    bus(PBR_OFS_LOAD_CTRL, 32'h2, 1'b1);
    rchk(PBR_OFS_LOAD_CTRL, 32'h0);
    bus(PBR_OFS_LOAD_CTRL, 32'h3, 1'b1);
    rchk(PBR_OFS_LOAD_CTRL, 32'h0);
    pulse_reload();
    chk(32'(active_set.prescale), 32'h2);
    bus(PBR_OFS_LOAD_CTRL, 32'h4, 1'b1);
    chk(32'({n_frc[7:0], n_rst[7:0]}), 32'h0101);
    bus(PBR_OFS_SETUP, 32'h00000100, 1'b1);
    bus(PBR_OFS_LOAD_CTRL, 32'h4, 1'b1);
    chk(32'(n_frc), 32'h1);
    // Reset in mid-run drops an armed load and clears the active set.
    bus(PBR_OFS_LOAD_CTRL, 32'h1, 1'b1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk({shadow_load_ok, 12'h000, active_set.prescale, active_set.start}, 32'h0);
    init_signal <= 1'b1;
    @(posedge sys_clk);
    init_signal <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(32'(n_rst), 32'h2);
    report_and_stop();
  end
endmodule : tb_top
